// ===== logic/ebt_pkg.sv
// package for the eight-bit timer control block: map, fields, resets
package ebt_pkg;
    // register indices; the byte address is the index times four
    localparam logic [7:0] EBT_IDX_CTRL8 = 8'h00;
    localparam logic [7:0] EBT_IDX_COMMON = 8'h01;
    localparam logic [7:0] EBT_IDX_LOW8 = 8'h04;
    localparam logic [7:0] EBT_IDX_HIGH8 = 8'h05;
    localparam logic [7:0] EBT_IDX_LOW16 = 8'h06;
    localparam logic [7:0] EBT_IDX_STATUS = 8'h07;
    // eight_bit_control field positions
    localparam int EBT_B_RUN = 7;
    localparam int EBT_B_SINGLE = 6;
    localparam int EBT_B_TOUT = 5;
    localparam int EBT_B_PS_HI = 4;
    localparam int EBT_B_PS_LO = 3;
    localparam int EBT_B_CAP_IE = 2;
    localparam int EBT_B_TO_IE = 1;
    localparam int EBT_B_OUTSEL = 0;
    // common_timer_control field positions
    localparam int EBT_B_MODE = 7;
    localparam int EBT_B_PIN2 = 6;
    // reset values
    localparam logic [7:0] EBT_RST_CTRL8 = 8'h00;
    localparam logic [7:0] EBT_RST_COMMON = 8'h00;
    localparam logic [7:0] EBT_RST_HOLD = 8'h00;
    // bus answers
    localparam logic [1:0] EBT_RESP_OKAY = 2'h0;
    localparam logic [1:0] EBT_RESP_SLVERR = 2'h2;
    // counter phases, gray coded
    typedef enum logic [1:0] {
        EBT_IDLE = 2'b00,
        EBT_HIGH = 2'b01,
        EBT_LOW = 2'b11
    } ebt_phase_t;
    // pin-facing outputs travel together
    typedef struct packed {
        logic first_pin;
        logic second_pin;
        logic second_pin_oe;
        logic demod_from_second;
    } ebt_pins_t;
endpackage

// ===== logic/ebt_timer.sv
// eight-bit timer control, hold registers and axi4-lite slave
// Functional notes
// RULE1: run bit starts, stops, reads running state
// RULE2: bit six picks repeating or single pass
// RULE3: timeout flag reads one after timeout
// RULE4: writing one clears flag, zero keeps
// RULE5: prescale select divides clock by 1,2,4,8
// RULE6: capture interrupt when enabled in demodulation
// RULE7: timeout interrupt request when enabled
// RULE8: output select routes port or waveform
// RULE9: common bit seven selects transmit or demodulation
// RULE10: transmit, bit six zero keeps port output
// RULE11: bit six drives counter out or demod pin
// RULE12: high and low hold registers, read/write
// RULE13: wide low byte hold register, read/write
// RULE14: software stops counters before mode change
// RULE15: timeout enable bit1, output select bit0
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module ebt_timer
    import ebt_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic port_out_first,
    input wire logic port_out_second,
    input wire logic wide_counter_out,
    input wire logic capture_event,
    output ebt_pins_t pins,
    output logic timeout_irq,
    output logic capture_irq
);
    // elaboration check: status index needs five address bits
    if (ADDR_W < 5) begin
        $error("ADDR_W too small for register map");
    end

    // register index from byte address
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return 8'(a >> 2);
    endfunction

    // a word counts as mapped when its index is one of ours
    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == EBT_IDX_CTRL8 || idx == EBT_IDX_COMMON || idx == EBT_IDX_LOW8
            || idx == EBT_IDX_HIGH8 || idx == EBT_IDX_LOW16 || idx == EBT_IDX_STATUS;
    endfunction

    logic [7:0] ctrl_reg;
    logic [7:0] common_reg;
    logic [7:0] low_hold_reg;
    logic [7:0] high_hold_reg;
    logic [7:0] wide_low_reg;
    logic [ADDR_W-1:0] aw_reg;
    logic aw_full_reg;
    logic [7:0] wd_reg;
    logic wd_strb_reg;
    logic wd_full_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [7:0] count_reg;
    logic [2:0] pre_reg;
    ebt_phase_t phase_reg;
    logic wave_reg;
    logic timeout_irq_reg;
    logic capture_irq_reg;

    // address and data are latched separately so either may come first
    assign s_axi_awready = !aw_full_reg && !bvalid_reg;
    assign s_axi_wready = !wd_full_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    logic wr_fire;
    logic [7:0] wr_idx;
    assign wr_fire = aw_full_reg && wd_full_reg && !bvalid_reg;
    assign wr_idx = reg_index(aw_reg);

    // write-channel capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg <= 1'b0;
            aw_reg <= '0;
            wd_full_reg <= 1'b0;
            wd_reg <= 8'h00;
            wd_strb_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                aw_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full_reg <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wd_full_reg <= 1'b1;
                wd_reg <= s_axi_wdata[7:0];
                wd_strb_reg <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                wd_full_reg <= 1'b0;
            end
        end
    end

    // write response, slverr on unmapped word
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= EBT_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= is_mapped(wr_idx) ? EBT_RESP_OKAY : EBT_RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    logic wr_ok;
    assign wr_ok = wr_fire && wd_strb_reg;

    logic tc_hit;
    logic tick;

    // eight_bit_control; the flag's set beats a same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_reg <= EBT_RST_CTRL8;
        end else begin
            if (wr_ok && wr_idx == EBT_IDX_CTRL8) begin
                // RULE1 RULE2 RULE5 run, style, prescale
                ctrl_reg[EBT_B_RUN] <= wd_reg[EBT_B_RUN];
                ctrl_reg[EBT_B_SINGLE] <= wd_reg[EBT_B_SINGLE];
                ctrl_reg[EBT_B_PS_HI:EBT_B_PS_LO] <= wd_reg[EBT_B_PS_HI:EBT_B_PS_LO];
                // RULE6 RULE15 enables and select
                ctrl_reg[EBT_B_CAP_IE] <= wd_reg[EBT_B_CAP_IE];
                ctrl_reg[EBT_B_TO_IE] <= wd_reg[EBT_B_TO_IE];
                ctrl_reg[EBT_B_OUTSEL] <= wd_reg[EBT_B_OUTSEL];
                // RULE4 write one clears
                if (wd_reg[EBT_B_TOUT]) begin
                    ctrl_reg[EBT_B_TOUT] <= 1'b0;
                end
            end
            // RULE3 timeout sets flag
            if (tc_hit) begin
                ctrl_reg[EBT_B_TOUT] <= 1'b1;
            end
            // RULE2 single pass stops at terminal count
            if (tc_hit && ctrl_reg[EBT_B_SINGLE]) begin
                ctrl_reg[EBT_B_RUN] <= 1'b0;
            end
        end
    end

    // common control and holds
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            common_reg <= EBT_RST_COMMON;
            low_hold_reg <= EBT_RST_HOLD;
            high_hold_reg <= EBT_RST_HOLD;
            wide_low_reg <= EBT_RST_HOLD;
        end else if (wr_ok) begin
            // RULE9 mode bit; RULE14 no guard against a running switch
            if (wr_idx == EBT_IDX_COMMON) begin
                common_reg[EBT_B_MODE] <= wd_reg[EBT_B_MODE];
                common_reg[EBT_B_PIN2] <= wd_reg[EBT_B_PIN2];
            end
            // RULE12 eight-bit holds
            if (wr_idx == EBT_IDX_LOW8) begin
                low_hold_reg <= wd_reg;
            end
            if (wr_idx == EBT_IDX_HIGH8) begin
                high_hold_reg <= wd_reg;
            end
            // RULE13 wide low byte
            if (wr_idx == EBT_IDX_LOW16) begin
                wide_low_reg <= wd_reg;
            end
        end
    end

    // read mux; reserved bits read zero
    function automatic logic [7:0] read_mux(input logic [7:0] idx);
        case (idx)
            EBT_IDX_CTRL8: return ctrl_reg;
            EBT_IDX_COMMON: return common_reg;
            EBT_IDX_LOW8: return low_hold_reg;
            EBT_IDX_HIGH8: return high_hold_reg;
            EBT_IDX_LOW16: return wide_low_reg;
            EBT_IDX_STATUS: return {6'h00, phase_reg};
            default: return 8'h00;
        endcase
    endfunction

    // read channel, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= EBT_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= {24'h00_0000, read_mux(reg_index(s_axi_araddr))};
            rresp_reg <= is_mapped(reg_index(s_axi_araddr)) ? EBT_RESP_OKAY
                                                            : EBT_RESP_SLVERR;
        end else if (s_axi_rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    // RULE5 prescaler: tick every 1,2,4 or 8 clocks
    always_ff @(posedge aclk) begin
        if (!aresetn || !ctrl_reg[EBT_B_RUN]) begin
            pre_reg <= 3'h0;
        end else begin
            pre_reg <= pre_reg + 3'h1;
        end
    end
    always_comb begin
        case (ctrl_reg[EBT_B_PS_HI:EBT_B_PS_LO])
            2'h0: tick = 1'b1;
            2'h1: tick = pre_reg[0];
            2'h2: tick = &pre_reg[1:0];
            default: tick = &pre_reg;
        endcase
    end

    // terminal count ends each low phase; a wave period is high then low
    assign tc_hit = ctrl_reg[EBT_B_RUN] && tick && phase_reg == EBT_LOW && count_reg == 8'h00;

    // RULE1 counter runs only while run bit set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg <= EBT_IDLE;
            count_reg <= 8'h00;
            wave_reg <= 1'b0;
        end else if (!ctrl_reg[EBT_B_RUN]) begin
            phase_reg <= EBT_IDLE;
            wave_reg <= 1'b0;
        end else if (tick) begin
            case (phase_reg)
                EBT_IDLE: begin
                    phase_reg <= EBT_HIGH;
                    count_reg <= high_hold_reg;
                    wave_reg <= 1'b1;
                end
                EBT_HIGH: begin
                    if (count_reg == 8'h00) begin
                        phase_reg <= EBT_LOW;
                        count_reg <= low_hold_reg;
                        wave_reg <= 1'b0;
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                EBT_LOW: begin
                    // RULE2 repeating reloads, single pass idles
                    if (count_reg == 8'h00) begin
                        phase_reg <= ctrl_reg[EBT_B_SINGLE] ? EBT_IDLE : EBT_HIGH;
                        count_reg <= high_hold_reg;
                        wave_reg <= !ctrl_reg[EBT_B_SINGLE];
                    end else begin
                        count_reg <= count_reg - 8'h01;
                    end
                end
                default: phase_reg <= EBT_IDLE;
            endcase
        end
    end

    // interrupt request pulses
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timeout_irq_reg <= 1'b0;
            capture_irq_reg <= 1'b0;
        end else begin
            // RULE7 timeout request
            timeout_irq_reg <= tc_hit && ctrl_reg[EBT_B_TO_IE];
            // RULE6 capture only in demodulation mode
            capture_irq_reg <= capture_event && ctrl_reg[EBT_B_CAP_IE]
                               && common_reg[EBT_B_MODE];
        end
    end
    assign timeout_irq = timeout_irq_reg;
    assign capture_irq = capture_irq_reg;

    // pin routing; pin-two drive only in transmit mode
    always_comb begin
        // RULE8 first pin route
        pins.first_pin = ctrl_reg[EBT_B_OUTSEL] ? wave_reg : port_out_first;
        // RULE10 RULE11 second pin route
        pins.second_pin = (common_reg[EBT_B_PIN2] && !common_reg[EBT_B_MODE])
                          ? (wave_reg | wide_counter_out) : port_out_second;
        pins.second_pin_oe = !common_reg[EBT_B_MODE];
        pins.demod_from_second = common_reg[EBT_B_MODE] && common_reg[EBT_B_PIN2];
    end

    // a_flag_sets: timeout always lands in flag
    a_flag_sets: assert property (@(posedge aclk) disable iff (!aresetn) // RULE3
        tc_hit |=> ctrl_reg[EBT_B_TOUT]) else $error("timeout flag not set");
    a_flag_clear: assert property (@(posedge aclk) disable iff (!aresetn) // RULE4
        wr_ok && wr_idx == EBT_IDX_CTRL8 && wd_reg[EBT_B_TOUT] && !tc_hit
        |=> !ctrl_reg[EBT_B_TOUT]) else $error("flag clear failed");
    a_single_stops: assert property (@(posedge aclk) disable iff (!aresetn) // RULE2
        tc_hit && ctrl_reg[EBT_B_SINGLE] |=> !ctrl_reg[EBT_B_RUN])
        else $error("single pass kept running");
    a_run_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE1
        wr_ok && wr_idx == EBT_IDX_CTRL8 && !tc_hit
        |=> ctrl_reg[EBT_B_RUN] == $past(wd_reg[EBT_B_RUN])) else $error("run bit wrong");
    a_to_irq: assert property (@(posedge aclk) disable iff (!aresetn) // RULE7
        timeout_irq |-> $past(tc_hit) && $past(ctrl_reg[EBT_B_TO_IE]))
        else $error("spurious timeout irq");
    a_cap_irq: assert property (@(posedge aclk) disable iff (!aresetn) // RULE6
        capture_irq |-> $past(common_reg[EBT_B_MODE]) && $past(ctrl_reg[EBT_B_CAP_IE]))
        else $error("spurious capture irq");
    a_first_route: assert property (@(posedge aclk) disable iff (!aresetn) // RULE8
        !ctrl_reg[EBT_B_OUTSEL] |-> pins.first_pin == port_out_first)
        else $error("first pin misrouted");
    a_second_port: assert property (@(posedge aclk) disable iff (!aresetn) // RULE10
        !common_reg[EBT_B_MODE] && !common_reg[EBT_B_PIN2]
        |-> pins.second_pin == port_out_second) else $error("second pin misrouted");
    a_hold_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE12
        wr_ok && wr_idx == EBT_IDX_HIGH8 |=> high_hold_reg == $past(wd_reg))
        else $error("high hold not written");
    a_wide_write: assert property (@(posedge aclk) disable iff (!aresetn) // RULE13
        wr_ok && wr_idx == EBT_IDX_LOW16 |=> wide_low_reg == $past(wd_reg))
        else $error("wide low not written");
    c_timeout: cover property (@(posedge aclk) tc_hit);
    c_single: cover property (@(posedge aclk) tc_hit && ctrl_reg[EBT_B_SINGLE]);
    c_capture: cover property (@(posedge aclk) capture_irq);
endmodule
`default_nettype wire

// ===== dv/ebt_pin_model.sv
// pin-side partner: port output levels, wide counter level, capture pulses
`timescale 1ns/1ps
`default_nettype none
module ebt_pin_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic cap_req,
    input wire logic wide_lvl,
    output logic port_out_first,
    output logic port_out_second,
    output logic wide_counter_out,
    output logic capture_event
);
    // port levels change every cycle so a stale route cannot pass
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_out_first <= 1'b0;
        end else begin
            port_out_first <= ~port_out_first;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_event <= 1'b0;
        end else begin
            capture_event <= cap_req & ~capture_event;
        end
    end
    // second port level is the inverse, wide level follows request
    assign port_out_second = ~port_out_first;
    assign wide_counter_out = wide_lvl;
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// self-checking bench for the eight-bit timer control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ebt_pkg::*;
    localparam logic [7:0] A_CTRL = 8'(EBT_IDX_CTRL8 * 4);
    localparam logic [7:0] A_COM = 8'(EBT_IDX_COMMON * 4);
    localparam logic [7:0] A_LO8 = 8'(EBT_IDX_LOW8 * 4);
    localparam logic [7:0] A_HI8 = 8'(EBT_IDX_HIGH8 * 4);
    localparam logic [7:0] A_LO16 = 8'(EBT_IDX_LOW16 * 4);
    logic aclk = 1'b0;
    logic aresetn, awvalid, wvalid, bready, arvalid, rready, cap_req, wide_lvl;
    logic awready, wready, bvalid, arready, rvalid, timeout_irq, capture_irq;
    logic pf, ps, wco, cev;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    ebt_pins_t pins;
    int error_cnt = 0;
    int checks_done = 0;
    int to_cnt = 0;
    int cap_cnt = 0;
    always #20 aclk = ~aclk;
    ebt_timer u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .port_out_first(pf), .port_out_second(ps),
        .wide_counter_out(wco), .capture_event(cev), .pins(pins),
        .timeout_irq(timeout_irq), .capture_irq(capture_irq));
    ebt_pin_model u_pins (.aclk(aclk), .aresetn(aresetn), .cap_req(cap_req),
        .wide_lvl(wide_lvl), .port_out_first(pf), .port_out_second(ps),
        .wide_counter_out(wco), .capture_event(cev));
    // irq pulses last one cycle, so count them mid-cycle
    always @(negedge aclk) begin
        if (timeout_irq === 1'b1) to_cnt++;
        if (capture_irq === 1'b1) cap_cnt++;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // ready is judged before the edge, release only after it
    // no cycle limit here: only the watchdog ends a hung transfer
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        logic aw_t, w_t, b_t;
        b_t = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!b_t) begin
            @(negedge aclk);
            aw_t = awvalid && awready;
            w_t = wvalid && wready;
            b_t = bvalid;
            if (b_t) chk(32'(bresp), 32'(er));
            @(posedge aclk);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        logic ar_t, r_t;
        r_t = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!r_t) begin
            @(negedge aclk);
            ar_t = arvalid && arready;
            r_t = rvalid;
            if (r_t) chk(rdata, {24'h0, e});
            if (r_t) chk(32'(rresp), 32'(er));
            @(posedge aclk);
            if (ar_t) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask
    task automatic wait_to(output int cyc);
        cyc = 0;
        do begin
            @(negedge aclk);
            cyc++;
        end while (timeout_irq !== 1'b1 && cyc < 300);
    endtask
    task automatic cap_pulse();
        @(posedge aclk);
        cap_req <= 1'b1;
        @(posedge aclk);
        cap_req <= 1'b0;
        repeat (4) @(negedge aclk);
    endtask
    task automatic t_reset();
        rd(A_CTRL, EBT_RST_CTRL8, EBT_RESP_OKAY);
        rd(A_COM, EBT_RST_COMMON, EBT_RESP_OKAY);
        rd(A_LO8, EBT_RST_HOLD, EBT_RESP_OKAY);
        rd(A_HI8, EBT_RST_HOLD, EBT_RESP_OKAY);
        rd(A_LO16, EBT_RST_HOLD, EBT_RESP_OKAY);
        $display("test reset done");
    endtask
    task automatic t_hold();
        logic [7:0] al [3];
        al = '{A_LO8, A_HI8, A_LO16};
        foreach (al[i]) begin
            wr(al[i], 8'ha5 ^ 8'(i), EBT_RESP_OKAY);
            rd(al[i], 8'ha5 ^ 8'(i), EBT_RESP_OKAY);
        end
        // unmapped word answers with an error and reads zero
        rd(8'h0c, 8'h00, EBT_RESP_SLVERR);
        wr(8'h08, 8'hff, EBT_RESP_SLVERR);
        $display("test hold done");
    endtask
    task automatic t_prescale();
        int c;
        wr(A_HI8, 8'h02, EBT_RESP_OKAY);
        wr(A_LO8, 8'h03, EBT_RESP_OKAY);
        // period is (2+1)+(3+1) ticks, each tick 2**code clocks
        for (int p = 0; p < 4; p++) begin
            wr(A_CTRL, 8'h82 | 8'(p << 3), EBT_RESP_OKAY);
            wait_to(c);
            wait_to(c);
            chk(32'(c), 32'(7 << p));
            wr(A_CTRL, 8'h00, EBT_RESP_OKAY);
        end
        rd(A_CTRL, 8'h20, EBT_RESP_OKAY);
        wr(A_CTRL, 8'h20, EBT_RESP_OKAY);
        rd(A_CTRL, 8'h00, EBT_RESP_OKAY);
        $display("test prescale done");
    endtask
    task automatic t_single();
        int c0;
        c0 = to_cnt;
        wr(A_CTRL, 8'hc0, EBT_RESP_OKAY);
        repeat (40) @(negedge aclk);
        rd(A_CTRL, 8'h60, EBT_RESP_OKAY);
        chk(32'(to_cnt - c0), 32'h0);
        wr(A_CTRL, 8'h20, EBT_RESP_OKAY);
        $display("test single done");
    endtask
    task automatic t_pins();
        logic a;
        int n;
        wr(A_COM, 8'h00, EBT_RESP_OKAY);
        repeat (3) begin
            @(negedge aclk);
            chk(32'(pins.first_pin), 32'(pf));
            chk(32'(pins.second_pin), 32'(ps));
            chk(32'(pins.second_pin_oe), 32'h1);
        end
        wr(A_CTRL, 8'h01, EBT_RESP_OKAY);
        @(negedge aclk);
        a = pins.first_pin;
        @(negedge aclk);
        chk(32'(pins.first_pin), 32'(a));
        // holds still 2 and 3: any 14 clocks of the wave hold 2*(2+1) highs
        wr(A_CTRL, 8'h81, EBT_RESP_OKAY);
        n = 0;
        repeat (14) begin
            @(negedge aclk);
            if (pins.first_pin === 1'b1) n++;
        end
        chk(32'(n), 32'h6);
        wr(A_CTRL, 8'h20, EBT_RESP_OKAY);
        wr(A_COM, 8'h40, EBT_RESP_OKAY);
        wide_lvl <= 1'b1;
        repeat (2) @(negedge aclk);
        chk(32'(pins.second_pin), 32'h1);
        @(posedge aclk);
        wide_lvl <= 1'b0;
        repeat (2) begin
            @(negedge aclk);
            chk(32'(pins.second_pin), 32'h0);
        end
        $display("test pins done");
    endtask
    task automatic t_demod();
        int c0;
        wr(A_CTRL, 8'h00, EBT_RESP_OKAY);
        wr(A_COM, 8'hc0, EBT_RESP_OKAY);
        @(negedge aclk);
        chk(32'(pins.demod_from_second), 32'h1);
        chk(32'(pins.second_pin_oe), 32'h0);
        wr(A_CTRL, 8'h04, EBT_RESP_OKAY);
        c0 = cap_cnt;
        cap_pulse();
        chk(32'(cap_cnt - c0), 32'h1);
        wr(A_CTRL, 8'h00, EBT_RESP_OKAY);
        cap_pulse();
        chk(32'(cap_cnt - c0), 32'h1);
        wr(A_COM, 8'h80, EBT_RESP_OKAY);
        @(negedge aclk);
        chk(32'(pins.demod_from_second), 32'h0);
        wr(A_COM, 8'h00, EBT_RESP_OKAY);
        // capture enabled in transmit mode must stay silent
        wr(A_CTRL, 8'h04, EBT_RESP_OKAY);
        cap_pulse();
        chk(32'(cap_cnt - c0), 32'h1);
        wr(A_CTRL, 8'h00, EBT_RESP_OKAY);
        $display("test demod done");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // watchdog: all tests need well under 3000 cycles
    initial begin
        repeat (8000) @(posedge aclk);
        error_cnt++;
        summarize();
    end
    // main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, cap_req, wide_lvl} = 8'h00;
        awaddr = 8'h00;
        araddr = 8'h00;
        wdata = 32'h0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_hold();
        t_prescale();
        t_single();
        t_pins();
        t_demod();
        summarize();
    end
endmodule
`default_nettype wire
